/* File: power_mode_controller.sv */
// module: operating mode controller with apb control and debug command gating
`timescale 1ns/1ps

// What this block does
// - mode pin high at reset enters run
// - pin low, command, halt, breakpoint enter background
// - background mode keeps cpu suspended
// - non-intrusive commands run in run or background
// - cpu register, trace, go only in background
// - wait stops cpu clock, clears interrupt mask
// - any interrupt wakes wait into service stacking
// - wait/stop allow only background and status commands
// - background command wakes wait into background
// - stop disabled gives illegal opcode reset
// - debug enabled selects shallow stop with debug
// - both lowvolt bits select shallow stop, regulator
// - otherwise partial powerdown select picks deep stop
// - every stop halts bus and cpu clocks
// - shallow stop retains all state
// - shallow stop leaves on reset or interrupts
// - debug enabled stop keeps debug clocks, regulation
// - background command wakes stop only if enabled
// - deep stop latches pins, powers down logic
// - deep stop exits on reset or counter wake
// - flag and pin latch hold until acknowledged
// - sixteen debug clocks per bit time
module power_mode_controller (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic DEBUG_MODE_SELECT_PIN,
    input wire logic DEBUG_HALT_INSTRUCTION,
    input wire logic BREAKPOINT_HIT,
    input wire logic WAIT_INSTRUCTION,
    input wire logic STOP_INSTRUCTION,
    input wire logic ANY_IRQ,
    input wire logic STOP_WAKE_IRQ,
    input wire logic COUNTER_WAKE,
    input wire logic FORCE_DEBUG_RESET,
    input wire logic DBG_REQ_VALID,
    input wire logic [2:0] DBG_REQ_CMD,
    input wire logic [7:0] PADDR,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic [2:0] MODE,
    output logic CPU_CLK_EN,
    output logic BUS_CLK_EN,
    output logic DEBUG_CLK_EN,
    output logic REGULATOR_FULL,
    output logic CORE_POWER_ON,
    output logic PIN_LATCH_HOLD,
    output logic CLEAR_INT_MASK,
    output logic START_STACKING,
    output logic ILLEGAL_OPCODE_RESET,
    output logic VECTOR_FETCH,
    output logic [15:0] VECTOR_ADDR,
    output logic LOWVOLT_RESET_EN,
    output logic DBG_ACCEPT,
    output logic DBG_EXECUTE,
    output logic DBG_STATUS_ERR,
    output logic DEBUG_BIT_TICK
);

    // ************************************************************
    // state record
    // ************************************************************
    typedef struct packed {
        logic pin_meta;               // first synchroniser stage
        logic pin_sync;               // second stage, only stage logic reads
        pmc_pkg::op_mode_t mode;      // current operating mode
        pmc_pkg::ctl_bits_t ctl;      // software control bits
        logic ppd_flag;               // partial power-down flag
        logic pin_hold;               // pin latches closed
        logic clr_mask;               // pulse: clear interrupt mask
        logic stacking;               // pulse: start interrupt stacking
        logic illegal;                // pulse: illegal opcode reset
        logic vfetch;                 // pulse: fetch reset vector
        logic lv_reset;               // low-voltage reset enabled
        pmc_pkg::dbg_rsp_t rsp;       // registered debug answer
        logic [4:0] bit_cnt;          // debug bit-time divider
        logic tick;                   // pulse every bit time
        logic [31:0] rdata;           // apb read data
        logic ready;                  // apb ready
        logic slverr;                 // apb error
        logic [4:0] lvl;              // registered level outputs
    } state_t;

    state_t st_reg;
    state_t st_next;
    logic apb_access;                 // access phase this cycle
    logic apb_hit;                    // decoded address
    pmc_pkg::dbg_req_t req;           // incoming debug request
    logic non_intrusive;              // command allowed outside background
    logic wake_allowed;               // background command may wake
    logic next_stop;                  // stop mode in the next state

    assign req.valid = DBG_REQ_VALID;
    assign req.cmd = pmc_pkg::dbg_cmd_t'(DBG_REQ_CMD);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        st_next = st_reg;
        // pulses drop unless set below
        st_next.clr_mask = 1'b0;
        st_next.stacking = 1'b0;
        st_next.illegal = 1'b0;
        st_next.vfetch = 1'b0;
        st_next.rsp = '0;
        st_next.ready = 1'b0;
        st_next.slverr = 1'b0;
        // external pin: two flops before any logic
        st_next.pin_meta = DEBUG_MODE_SELECT_PIN;
        st_next.pin_sync = st_reg.pin_meta;

        // divider gives one tick per sixteen clocks
        st_next.tick = 1'b0;
        if (st_reg.bit_cnt == pmc_pkg::DEBUG_BIT_COUNT - 5'h01) begin
            st_next.bit_cnt = 5'h00;
            st_next.tick = 1'b1;
        end else begin
            st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
        end

        non_intrusive = req.cmd inside {pmc_pkg::CMD_MEM_ACCESS, pmc_pkg::CMD_MEM_STATUS,
                                        pmc_pkg::CMD_CTRL_REG, pmc_pkg::CMD_BACKGROUND};
        wake_allowed = req.valid && req.cmd == pmc_pkg::CMD_BACKGROUND;

        // ********************************************************
        // mode sequencing
        // ********************************************************
        unique case (st_reg.mode)
            pmc_pkg::MODE_RESET: begin
                // sampled pin high leaves into run with vector fetch
                if (st_reg.pin_sync) begin
                    st_next.mode = pmc_pkg::MODE_RUN;
                    st_next.vfetch = 1'b1;
                end else begin
                    st_next.mode = pmc_pkg::MODE_BACKGROUND;
                end
            end
            pmc_pkg::MODE_RUN: begin
                if (req.valid && non_intrusive) begin
                    st_next.rsp.accept = 1'b1;
                    st_next.rsp.execute = 1'b1;
                end
                // background entries take priority over instructions
                if (wake_allowed || DEBUG_HALT_INSTRUCTION || BREAKPOINT_HIT) begin
                    st_next.mode = pmc_pkg::MODE_BACKGROUND;
                end else if (WAIT_INSTRUCTION) begin
                    // cpu clock stops, interrupt mask cleared
                    st_next.mode = pmc_pkg::MODE_WAIT;
                    st_next.clr_mask = 1'b1;
                end else if (STOP_INSTRUCTION) begin
                    // selection uses bits as they stand now
                    if (!st_reg.ctl.stop_allow) begin
                        st_next.illegal = 1'b1;
                        st_next.mode = pmc_pkg::MODE_RESET;
                    end else if (st_reg.ctl.debug_enable) begin
                        st_next.mode = pmc_pkg::MODE_SHALLOW_STOP;
                    // lowvolt on in stop keeps shallow stop
                    end else if (st_reg.ctl.lowvolt_on && st_reg.ctl.lowvolt_stop) begin
                        st_next.mode = pmc_pkg::MODE_SHALLOW_STOP;
                    // partial power-down select picks the depth
                    end else if (st_reg.ctl.ppd_select) begin
                        st_next.mode = pmc_pkg::MODE_DEEP_STOP;
                    end else begin
                        st_next.mode = pmc_pkg::MODE_SHALLOW_STOP;
                    end
                end
            end
            pmc_pkg::MODE_BACKGROUND: begin
                // cpu stays suspended, only commands served
                if (req.valid) begin
                    st_next.rsp.accept = 1'b1;
                    st_next.rsp.execute = 1'b1;
                    if (req.cmd == pmc_pkg::CMD_GO) begin
                        st_next.mode = pmc_pkg::MODE_RUN;
                    end
                end
            end
            pmc_pkg::MODE_WAIT: begin
                // only background and status commands answered
                if (req.valid && req.cmd == pmc_pkg::CMD_MEM_STATUS) begin
                    st_next.rsp.accept = 1'b1;
                    st_next.rsp.status_err = 1'b1;
                end
                if (wake_allowed) begin
                    // background command wakes straight into background
                    st_next.rsp.accept = 1'b1;
                    st_next.rsp.execute = 1'b1;
                    st_next.mode = pmc_pkg::MODE_BACKGROUND;
                end else if (ANY_IRQ) begin
                    st_next.mode = pmc_pkg::MODE_RUN;
                    st_next.stacking = 1'b1;
                end
            end
            pmc_pkg::MODE_SHALLOW_STOP: begin
                // status commands report stop, no memory access
                // debug clocks only run when debug enabled
                if (st_reg.ctl.debug_enable && req.valid && req.cmd == pmc_pkg::CMD_MEM_STATUS) begin
                    st_next.rsp.accept = 1'b1;
                    st_next.rsp.status_err = 1'b1;
                end
                // background wakes only with debug enabled
                if (wake_allowed && st_reg.ctl.debug_enable) begin
                    st_next.rsp.accept = 1'b1;
                    st_next.rsp.execute = 1'b1;
                    st_next.mode = pmc_pkg::MODE_BACKGROUND;
                // listed interrupt sources wake into their vector
                end else if (STOP_WAKE_IRQ) begin
                    st_next.mode = pmc_pkg::MODE_RUN;
                    st_next.stacking = 1'b1;
                end
            end
            pmc_pkg::MODE_DEEP_STOP: begin
                // counter wake restarts as from power-on
                if (COUNTER_WAKE) begin
                    st_next = '0;
                    st_next.mode = pmc_pkg::MODE_RESET;
                    st_next.ctl = pmc_pkg::CTL_RESET;
                    st_next.lv_reset = 1'b1;
                    st_next.pin_meta = DEBUG_MODE_SELECT_PIN;
                    st_next.pin_sync = st_reg.pin_meta;
                    // flag set and latches stay closed
                    st_next.ppd_flag = 1'b1;
                    st_next.pin_hold = 1'b1;
                end
            end
            default: st_next.mode = pmc_pkg::MODE_RESET;
        endcase

        // forced debug reset restarts with the pin sampled again
        if (FORCE_DEBUG_RESET) begin
            st_next.mode = pmc_pkg::MODE_RESET;
        end

        // ********************************************************
        // apb slave: answers in the access cycle's next edge
        // ********************************************************
        apb_access = PSEL && PENABLE && !st_reg.ready;
        apb_hit = PADDR inside {pmc_pkg::ADDR_CONTROL, pmc_pkg::ADDR_STATUS, pmc_pkg::ADDR_ACK};
        if (apb_access) begin
            st_next.ready = 1'b1;
            st_next.slverr = !apb_hit;
            st_next.rdata = 32'h00000000;
            if (PWRITE) begin
                if (PADDR == pmc_pkg::ADDR_CONTROL) begin
                    st_next.ctl.stop_allow = PWDATA[pmc_pkg::CTL_STOP_ALLOW];
                    st_next.ctl.debug_enable = PWDATA[pmc_pkg::CTL_DEBUG_ENABLE];
                    st_next.ctl.lowvolt_on = PWDATA[pmc_pkg::CTL_LOWVOLT_ON];
                    st_next.ctl.lowvolt_stop = PWDATA[pmc_pkg::CTL_LOWVOLT_STOP];
                    st_next.ctl.ppd_select = PWDATA[pmc_pkg::CTL_PPD_SELECT];
                end else if (PADDR == pmc_pkg::ADDR_ACK && PWDATA[pmc_pkg::ACK_PPD]) begin
                    // acknowledge opens latches and clears flag
                    // software must have restored ports before this
                    st_next.ppd_flag = 1'b0;
                    st_next.pin_hold = 1'b0;
                end
            end else if (PADDR == pmc_pkg::ADDR_CONTROL) begin
                st_next.rdata = {27'h0000000, st_reg.ctl};
            end else if (PADDR == pmc_pkg::ADDR_STATUS) begin
                st_next.rdata = {26'h0000000, st_reg.pin_hold, st_reg.ppd_flag, 1'b0, st_reg.mode};
            end
        end

        // latch and flag sets win over an acknowledge in the same cycle
        if (st_next.mode == pmc_pkg::MODE_DEEP_STOP) begin
            st_next.pin_hold = 1'b1;
        end
        if (st_reg.mode == pmc_pkg::MODE_DEEP_STOP && COUNTER_WAKE) begin
            st_next.ppd_flag = 1'b1;
            st_next.pin_hold = 1'b1;
        end

        // level outputs decoded from the next state so each leaves a flop
        next_stop = st_next.mode inside {pmc_pkg::MODE_SHALLOW_STOP, pmc_pkg::MODE_DEEP_STOP};
        st_next.lvl[0] = st_next.mode == pmc_pkg::MODE_RUN;
        st_next.lvl[1] = !next_stop;
        st_next.lvl[2] = !next_stop || (st_next.ctl.debug_enable &&
                         st_next.mode == pmc_pkg::MODE_SHALLOW_STOP);
        st_next.lvl[3] = !next_stop || st_next.ctl.debug_enable ||
                         (st_next.ctl.lowvolt_on && st_next.ctl.lowvolt_stop);
        st_next.lvl[4] = st_next.mode != pmc_pkg::MODE_DEEP_STOP;
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            st_reg <= '0;
            st_reg.mode <= pmc_pkg::MODE_RESET;
            st_reg.ctl <= pmc_pkg::CTL_RESET;
            st_reg.lv_reset <= 1'b1;
            // synchroniser keeps sampling so the pin level is valid at release
            st_reg.pin_meta <= DEBUG_MODE_SELECT_PIN;
            st_reg.pin_sync <= st_reg.pin_meta;
            st_reg.lvl <= 5'h1E;
        end else begin
            st_reg <= st_next;
        end
    end

    // ************************************************************
    // outputs, all from flops except the constant vector address
    // ************************************************************
    logic in_stop;
    assign in_stop = st_reg.mode inside {pmc_pkg::MODE_SHALLOW_STOP, pmc_pkg::MODE_DEEP_STOP};

    assign PRDATA = st_reg.rdata;
    assign PREADY = st_reg.ready;
    assign PSLVERR = st_reg.slverr;
    assign MODE = st_reg.mode;
    assign CPU_CLK_EN = st_reg.lvl[0];
    // bus clock halts in stop; state held by not clocking
    assign BUS_CLK_EN = st_reg.lvl[1];
    assign DEBUG_CLK_EN = st_reg.lvl[2];
    assign REGULATOR_FULL = st_reg.lvl[3];
    // internal circuits off in deep stop
    assign CORE_POWER_ON = st_reg.lvl[4];
    assign PIN_LATCH_HOLD = st_reg.pin_hold;
    assign CLEAR_INT_MASK = st_reg.clr_mask;
    assign START_STACKING = st_reg.stacking;
    assign ILLEGAL_OPCODE_RESET = st_reg.illegal;
    assign VECTOR_FETCH = st_reg.vfetch;
    assign VECTOR_ADDR = pmc_pkg::RESET_VECTOR_ADDR;
    assign LOWVOLT_RESET_EN = st_reg.lv_reset;
    assign DBG_ACCEPT = st_reg.rsp.accept;
    assign DBG_EXECUTE = st_reg.rsp.execute;
    assign DBG_STATUS_ERR = st_reg.rsp.status_err;
    assign DEBUG_BIT_TICK = st_reg.tick;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    sequence run_stop_disabled_s;
        st_reg.mode == pmc_pkg::MODE_RUN && STOP_INSTRUCTION && !st_reg.ctl.stop_allow
            && !DEBUG_HALT_INSTRUCTION && !BREAKPOINT_HIT && !WAIT_INSTRUCTION
            && !DBG_REQ_VALID && !FORCE_DEBUG_RESET;
    endsequence

    illegal_stop_a: assert property (run_stop_disabled_s |=> ILLEGAL_OPCODE_RESET)
        else $error("disabled stop did not reset");
    wait_mask_a: assert property (st_reg.mode != pmc_pkg::MODE_WAIT ##1
        st_reg.mode == pmc_pkg::MODE_WAIT |-> CLEAR_INT_MASK && !CPU_CLK_EN)
        else $error("wait entry without mask clear");
    bg_only_cmd_a: assert property (st_reg.mode == pmc_pkg::MODE_RUN && DBG_REQ_VALID
        && DBG_REQ_CMD == 3'h4 |=> !DBG_EXECUTE)
        else $error("cpu register command ran in run");
    stop_clocks_a: assert property (in_stop |-> !BUS_CLK_EN && !CPU_CLK_EN)
        else $error("clock running in stop");
    deep_latch_a: assert property (st_reg.mode == pmc_pkg::MODE_DEEP_STOP
        |-> PIN_LATCH_HOLD && !CORE_POWER_ON)
        else $error("deep stop without pin latch");
    stop_wake_gate_a: assert property (st_reg.mode == pmc_pkg::MODE_SHALLOW_STOP
        && !st_reg.ctl.debug_enable && !STOP_WAKE_IRQ && !FORCE_DEBUG_RESET
        |=> st_reg.mode == pmc_pkg::MODE_SHALLOW_STOP)
        else $error("stop left without cause");
    ppd_hold_a: assert property ($rose(st_reg.ppd_flag) |-> PIN_LATCH_HOLD)
        else $error("flag set with latches open");
    bit_tick_a: assert property (DEBUG_BIT_TICK |=> !DEBUG_BIT_TICK [*8])
        else $error("bit tick too frequent");
    debug_stop_a: assert property (st_reg.mode == pmc_pkg::MODE_SHALLOW_STOP
        && st_reg.ctl.debug_enable |-> DEBUG_CLK_EN && REGULATOR_FULL)
        else $error("debug clocks lost in stop");

endmodule

/* File: pmc_pkg.sv */
// package: mode, command and timing constants for the power mode controller
package pmc_pkg;

    // ************************************************************
    // operating modes
    // ************************************************************
    typedef enum logic [2:0] {
        MODE_RESET,
        MODE_RUN,
        MODE_BACKGROUND,
        MODE_WAIT,
        MODE_SHALLOW_STOP,
        MODE_DEEP_STOP
    } op_mode_t;

    // ************************************************************
    // debug command classes as decoded by the debug controller
    // ************************************************************
    typedef enum logic [2:0] {
        CMD_MEM_ACCESS,
        CMD_MEM_STATUS,
        CMD_CTRL_REG,
        CMD_BACKGROUND,
        CMD_CPU_REG,
        CMD_TRACE,
        CMD_GO
    } dbg_cmd_t;

    // ************************************************************
    // register map (apb byte addresses, one word each)
    // ************************************************************
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_ACK = 8'h08;

    // control register field positions
    localparam int CTL_STOP_ALLOW = 0;
    localparam int CTL_DEBUG_ENABLE = 1;
    localparam int CTL_LOWVOLT_ON = 2;
    localparam int CTL_LOWVOLT_STOP = 3;
    localparam int CTL_PPD_SELECT = 4;
    localparam logic [4:0] CTL_RESET = 5'h01;

    // acknowledge register field position
    localparam int ACK_PPD = 0;

    // reset vector location
    localparam logic [15:0] RESET_VECTOR_ADDR = 16'hFFFE;

    // ************************************************************
    // serial debug timing
    // ************************************************************
    localparam int DEBUG_CLKS_PER_BIT = 16;
    localparam logic [4:0] DEBUG_BIT_COUNT = 5'(DEBUG_CLKS_PER_BIT);

    // ************************************************************
    // grouped signals
    // ************************************************************
    typedef struct packed {
        logic valid;
        dbg_cmd_t cmd;
    } dbg_req_t;

    typedef struct packed {
        logic accept;
        logic execute;
        logic status_err;
    } dbg_rsp_t;

    typedef struct packed {
        logic stop_allow;
        logic debug_enable;
        logic lowvolt_on;
        logic lowvolt_stop;
        logic ppd_select;
    } ctl_bits_t;

endpackage

/* File: debug_host_model.sv */
// partner: debug host model on the mode pin and command request lines
`timescale 1ns/1ps
module debug_host_model (
    input wire logic clk,
    input wire logic hold_low,
    output logic pin,
    output logic req_valid,
    output logic [2:0] req_cmd
);
    // ****************************************
    // pin level and command requests
    // ****************************************
    // the pin has a pull-up, so a released pin reads high
    assign pin = !hold_low;
    initial begin
        req_valid = 1'h0;
        req_cmd = 3'h0;
    end
    task send(input logic [2:0] c);
        repeat (pmc_pkg::DEBUG_CLKS_PER_BIT - 2) @(posedge clk);
        req_valid <= 1'h1;
        req_cmd <= c;
        @(posedge clk);
        req_valid <= 1'h0;
        // an idle command line shows the inverse, never a stale code
        req_cmd <= ~c;
    endtask
endmodule

/* File: testbench.sv */
// testbench: mode entry, debug command gating and stop selection scenarios
`timescale 1ns/1ps
module testbench;
    // ****************************************
    // signals and design
    // ****************************************
    logic clk = 0, rst = 1, hold_low = 0, any_irq = 0, stop_irq = 0, ctr_wake = 0;
    logic [4:0] ev = 5'h00; // halt, breakpoint, wait, stop, force reset
    logic psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, pin, vld, cpu_en, bus_en, reg_full, core_on, pin_hold, lv_rst;
    logic clr_mask, stacking, illegal, vfetch, acc, exe, serr, dbg_clk, tick;
    logic [2:0] cmd, mode;
    logic [15:0] vaddr;
    logic [4:0] tbl [4] = '{5'h13, 5'h1D, 5'h01, 5'h19}; // control values for stop
    int bad_count = 0, checks = 0, cyc = 0, n = 0;
    debug_host_model host (.clk(clk), .hold_low(hold_low), .pin(pin), .req_valid(vld),
        .req_cmd(cmd));
    power_mode_controller dut (.SYS_CLK(clk), .RST(rst), .DEBUG_MODE_SELECT_PIN(pin),
        .DEBUG_HALT_INSTRUCTION(ev[0]), .BREAKPOINT_HIT(ev[1]), .WAIT_INSTRUCTION(ev[2]),
        .STOP_INSTRUCTION(ev[3]), .ANY_IRQ(any_irq), .STOP_WAKE_IRQ(stop_irq),
        .COUNTER_WAKE(ctr_wake), .FORCE_DEBUG_RESET(ev[4]), .DBG_REQ_VALID(vld),
        .DBG_REQ_CMD(cmd), .PADDR(paddr), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .MODE(mode),
        .CPU_CLK_EN(cpu_en), .BUS_CLK_EN(bus_en), .DEBUG_CLK_EN(dbg_clk), .REGULATOR_FULL(reg_full),
        .CORE_POWER_ON(core_on), .PIN_LATCH_HOLD(pin_hold), .CLEAR_INT_MASK(clr_mask),
        .START_STACKING(stacking), .ILLEGAL_OPCODE_RESET(illegal), .VECTOR_FETCH(vfetch),
        .VECTOR_ADDR(vaddr), .LOWVOLT_RESET_EN(lv_rst), .DBG_ACCEPT(acc),
        .DBG_EXECUTE(exe), .DBG_STATUS_ERR(serr), .DEBUG_BIT_TICK(tick));
    // ****************************************
    // tasks
    // ****************************************
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // apb transfer: request held until pready is seen high at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // one-cycle cpu event; outputs looked at just after the sampling edge
    task pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'h1;
        @(posedge clk);
        ev <= 5'h00;
        #1;
    endtask
    task dbg(input logic [2:0] c, input logic a, input logic [2:0] m);
        host.send(c);
        #1;
        check(acc, a);
        check(mode, m);
    endtask
    // bounded wait, since reset wake passes through pin synchronisation
    task wait_mode(input logic [2:0] m);
        for (int n = 0; n < 40 && mode !== m; n++) @(posedge clk) #1;
        check(mode, m);
    endtask
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            bad_count++;
            results;
        end
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        wait_mode(pmc_pkg::MODE_RUN);
        check(vfetch, 1'h1);
        check(vaddr, 16'hFFFE);
        // bit-time ticks stand sixteen clocks apart
        while (tick !== 1'h1) @(posedge clk) #1;
        @(posedge clk) #1;
        for (n = 1; tick !== 1'h1 && n < 40; n++) @(posedge clk) #1;
        check(n, pmc_pkg::DEBUG_CLKS_PER_BIT);
        apb(1'h0, pmc_pkg::ADDR_CONTROL, 32'h0);
        check(rd, 32'h1);
        apb(1'h0, 8'h0C, 32'h0);
        check(err, 1'h1);
        check(rd, 32'h0);
        apb(1'h0, pmc_pkg::ADDR_STATUS, 32'h0);
        check(rd[2:0], pmc_pkg::MODE_RUN);
        // command gating in run and background
        for (int c = 0; c < 3; c++) dbg(3'(c), 1'h1, pmc_pkg::MODE_RUN);
        for (int c = 4; c < 7; c++) dbg(3'(c), 1'h0, pmc_pkg::MODE_RUN);
        dbg(3'h3, 1'h1, pmc_pkg::MODE_BACKGROUND);
        check(cpu_en, 1'h0);
        check(exe, 1'h1);
        for (int c = 0; c < 6; c++) dbg(3'(c), 1'h1, pmc_pkg::MODE_BACKGROUND);
        dbg(3'h6, 1'h1, pmc_pkg::MODE_RUN);
        for (int i = 0; i < 2; i++) begin
            pulse(i);
            wait_mode(pmc_pkg::MODE_BACKGROUND);
            dbg(3'h6, 1'h1, pmc_pkg::MODE_RUN);
        end
        @(posedge clk) hold_low <= 1'h1;
        pulse(4);
        wait_mode(pmc_pkg::MODE_BACKGROUND);
        hold_low <= 1'h0;
        dbg(3'h6, 1'h1, pmc_pkg::MODE_RUN);
        // wait entry, gating and both exits
        pulse(2);
        check(clr_mask, 1'h1);
        wait_mode(pmc_pkg::MODE_WAIT);
        check({cpu_en, bus_en}, 2'h1);
        dbg(3'h0, 1'h0, pmc_pkg::MODE_WAIT);
        dbg(3'h1, 1'h1, pmc_pkg::MODE_WAIT);
        check(serr, 1'h1);
        check(exe, 1'h0);
        @(posedge clk) any_irq <= 1'h1;
        @(posedge clk) any_irq <= 1'h0;
        #1;
        check(stacking, 1'h1);
        wait_mode(pmc_pkg::MODE_RUN);
        pulse(2);
        dbg(3'h3, 1'h1, pmc_pkg::MODE_BACKGROUND);
        dbg(3'h6, 1'h1, pmc_pkg::MODE_RUN);
        apb(1'h1, pmc_pkg::ADDR_CONTROL, 32'h0);
        pulse(3);
        check(illegal, 1'h1);
        wait_mode(pmc_pkg::MODE_RUN);
        // stop selection from the bits at stop time
        for (int i = 0; i < 4; i++) begin
            apb(1'h1, pmc_pkg::ADDR_CONTROL, 32'(tbl[i]));
            pulse(3);
            wait_mode(i < 3 ? pmc_pkg::MODE_SHALLOW_STOP : pmc_pkg::MODE_DEEP_STOP);
            check({cpu_en, bus_en}, 2'h0);
            check(reg_full, i < 2);
            check(dbg_clk, i == 0);
            if (i == 0) dbg(3'h3, 1'h1, pmc_pkg::MODE_BACKGROUND);
            if (i == 0) dbg(3'h6, 1'h1, pmc_pkg::MODE_RUN);
            if (i == 2) dbg(3'h3, 1'h0, pmc_pkg::MODE_SHALLOW_STOP);
            if (i == 1 || i == 2) begin
                @(posedge clk) stop_irq <= 1'h1;
                wait_mode(pmc_pkg::MODE_RUN);
                stop_irq <= 1'h0;
            end
            if (i == 3) begin
                check({pin_hold, core_on}, 2'h2);
                @(posedge clk) ctr_wake <= 1'h1;
                wait_mode(pmc_pkg::MODE_RUN);
                ctr_wake <= 1'h0;
                check(lv_rst, 1'h1);
                apb(1'h0, pmc_pkg::ADDR_CONTROL, 32'h0);
                check(rd, 32'h1);
                apb(1'h0, pmc_pkg::ADDR_STATUS, 32'h0);
                check({pin_hold, rd[5:4]}, 3'h7);
                // no ports to restore here, so acknowledge at once
                apb(1'h1, pmc_pkg::ADDR_ACK, 32'h1);
                apb(1'h0, pmc_pkg::ADDR_STATUS, 32'h0);
                check({pin_hold, rd[5:4]}, 3'h0);
            end
        end
        results;
    end
endmodule
